// ### include/sensor_pkg.sv
// Purpose: Shared constants and types for the linear sensor readout sequencer
// Assumes: 32-bit APB register bus, one 200 MHz clock
// Notes: Dark level and reference values are plain defaults
package sensor_pkg;
  localparam int PIX_W = 12; // Held pixel level width
  localparam int IDX_W = 11; // Clock and pixel counter width
  localparam int ACC_W = 15; // Room for eight summed pixels
  localparam int FIFO_DEPTH = 4; // Output buffer depth
  // Register byte addresses
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STAT = 12'h004;
  // Control field positions
  localparam int CTRL_RES = 0; // Two resolution select bits
  localparam int CTRL_MODE = 2; // Combine mode, 1 = binning
  localparam int CTRL_VAR = 3; // Two array length bits
  // Status field positions
  localparam int STAT_ST = 0;
  localparam int STAT_PD = 3;
  localparam int STAT_INT = 4;
  localparam int STAT_FULL = 5;
  localparam int STAT_TEST = 6;
  localparam int STAT_GRP = 16;
  // Clock numbers after a start strobe
  localparam logic [IDX_W-1:0] SAMPLE_END = 11'h003; // Last sampling clock
  localparam logic [IDX_W-1:0] DISCH_END = 11'h009; // Last discharge clock
  localparam logic [IDX_W-1:0] DARK_END = 11'h010; // Last dark clock
  // Array lengths of the four variants
  localparam logic [IDX_W-1:0] N_1024 = 11'h400;
  localparam logic [IDX_W-1:0] N_960 = 11'h3c0;
  localparam logic [IDX_W-1:0] N_640 = 11'h280;
  localparam logic [IDX_W-1:0] N_320 = 11'h140;
  localparam logic [PIX_W-1:0] DARK_LEVEL = 12'h0c8; // Dark reference word
  localparam logic [PIX_W-1:0] PIX_MAX = 12'hfff; // Binning saturates here

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SAMPLE = 3'b001,
    ST_DISCH = 3'b010,
    ST_DARK = 3'b011,
    ST_READ = 3'b100
  } seq_state_type;

  // Software configuration, latched per line at start
  typedef struct packed {
    logic [1:0] variant;
    logic mode;
    logic [1:0] res;
  } cfg_type;

  // One output word request to the combiner
  typedef struct packed {
    logic dark;
    logic mode;
    logic [1:0] res;
    logic [IDX_W-1:0] base;
  } job_type;

  // Number of output groups for a variant and resolution
  function automatic logic [IDX_W-1:0] group_count(input logic [1:0] variant,
                                                    input logic [1:0] res);
    logic [IDX_W-1:0] n;
    unique case (variant)
      2'b00: n = N_1024;
      2'b01: n = N_960;
      2'b10: n = N_640;
      2'b11: n = N_320;
    endcase
    return n >> res;
  endfunction
endpackage

// ### verilog/pixel_fifo.sv
// Purpose: Small flop-based FIFO for the pixel stream
// Assumes: Same clock on both sides
// Notes: in_ready falls when full, which stalls the combiner
`timescale 1ns/1ps
`default_nettype none
module pixel_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem; // Storage words
    logic [AW-1:0] wp; // Write index
    logic [AW-1:0] rp; // Read index
    logic [CW-1:0] cnt; // Words held
  } fifo_type;

  fifo_type q_r;
  fifo_type q_nxt;
  logic push;
  logic pop;

  // Index advance with wrap, shared by both pointers
  function automatic logic [AW-1:0] nxt_ptr(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  assign in_ready = (q_r.cnt != CW'(DEPTH));
  assign out_valid = (q_r.cnt != '0);
  assign out_data = q_r.mem[q_r.rp];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Next state
  always_comb begin
    q_nxt = q_r;
    if (push) begin
      q_nxt.mem[q_r.wp] = in_data;
      q_nxt.wp = nxt_ptr(q_r.wp);
    end
    if (pop) begin
      q_nxt.rp = nxt_ptr(q_r.rp);
    end
    if (push && !pop) begin
      q_nxt.cnt = q_r.cnt + CW'(1);
    end else if (pop && !push) begin
      q_nxt.cnt = q_r.cnt - CW'(1);
    end
  end

  // State register, frozen while the enable is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_r <= '0;
    end else if (clk_en) begin
      q_r <= q_nxt;
    end
  end
endmodule
`default_nettype wire

// ### verilog/pixel_combiner.sv
// Purpose: Reads held pixels of one group and sums or averages them
// Assumes: hold_level_in answers hold_addr within the same cycle
// Notes: One group of 1, 2, 4 or 8 pixels takes that many cycles
`timescale 1ns/1ps
`default_nettype none
module pixel_combiner
  import sensor_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire job_type job,
  input wire logic job_valid,
  output logic job_ready,
  output logic [IDX_W-1:0] hold_addr,
  input wire logic [PIX_W-1:0] hold_level_in,
  output logic [PIX_W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  typedef struct packed {
    logic busy; // Walking a group
    logic mode; // 1 sums, 0 averages
    logic [1:0] res; // Group size as a shift
    logic [3:0] left; // Pixels still to read
    logic [IDX_W-1:0] addr; // Pixel now addressed
    logic [ACC_W-1:0] acc; // Running sum
    logic [PIX_W-1:0] out; // Finished word
    logic out_v; // Word waiting for the buffer
  } comb_type;

  comb_type q_r;
  comb_type q_nxt;
  logic [ACC_W-1:0] sum;

  assign job_ready = !q_r.busy && !q_r.out_v;
  assign hold_addr = q_r.addr;
  assign out_data = q_r.out;
  assign out_valid = q_r.out_v;
  assign sum = q_r.acc + ACC_W'(hold_level_in);

  // Next state
  always_comb begin
    q_nxt = q_r;
    if (q_r.out_v && out_ready) begin
      q_nxt.out_v = 1'b0;
    end
    if (job_valid && job_ready) begin
      if (job.dark) begin
        // Dark clocks show the reference level
        q_nxt.out = DARK_LEVEL; // R4
        q_nxt.out_v = 1'b1;
      end else begin
        q_nxt.busy = 1'b1;
        q_nxt.mode = job.mode;
        q_nxt.res = job.res;
        q_nxt.left = 4'h1 << job.res; // R9
        q_nxt.addr = job.base;
        q_nxt.acc = '0;
      end
    end else if (q_r.busy) begin
      q_nxt.acc = sum;
      q_nxt.addr = q_r.addr + IDX_W'(1);
      q_nxt.left = q_r.left - 4'h1;
      if (q_r.left == 4'h1) begin
        q_nxt.busy = 1'b0;
        q_nxt.out_v = 1'b1;
        // Binning clips at full scale; averaging keeps the scale
        if (q_r.mode) begin
          q_nxt.out = (sum > ACC_W'(PIX_MAX)) ? PIX_MAX : sum[PIX_W-1:0]; // R10
        end else begin
          q_nxt.out = PIX_W'(sum >> q_r.res); // R10
        end
      end
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_r <= '0;
    end else if (clk_en) begin
      q_r <= q_nxt;
    end
  end
endmodule
`default_nettype wire

// ### verilog/sensor_sequencer.sv
// Purpose: Start, sample, discharge and readout sequencer of a line sensor
// Assumes: Sensor clock, start, shutter and supply pins are asynchronous
// Notes: Pixel words leave through a four-word buffer with back-pressure
// What this block does
// R1 - Accepted start begins new integration
// R2 - Start taken on sensor clock rise
// R3 - Nine clocks sample then discharge
// R4 - Seven clocks of dark reference
// R5 - Each later clock outputs next pixel
// R6 - Line ends after sixteen plus N clocks
// R7 - Extra clocks restart readout, no resample
// R8 - Two select bits choose resolution
// R9 - Codes output N, N/2, N/4, N/8
// R10 - Mode bit picks binning or averaging
// R11 - Shutter acts on all pixels together
// R12 - Shutter high disconnects photodiodes, holds charge
// R13 - Drive active-low power-down reset output
// R14 - Test mode input stays grounded
// R15 - Power-down keeps sequencer idle, discharged
`timescale 1ns/1ps
`default_nettype none
module sensor_sequencer
  import sensor_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sensor_clk_in,
  input wire logic start_in,
  input wire logic shutter_hold_in,
  input wire logic supply_ok_in,
  input wire logic test_mode_enable_in,
  output logic power_down_reset_n,
  output logic hold_capture,
  output logic cap_discharge,
  output logic photodiode_connect,
  output logic line_done,
  output logic [IDX_W-1:0] hold_addr,
  input wire logic [PIX_W-1:0] hold_level_in,
  output logic [PIX_W-1:0] analog_pixel_out,
  output logic pixel_valid,
  input wire logic pixel_ready
);
  typedef struct packed {
    logic lclk_m, lclk_s, lclk_p; // Sensor clock sync and edge
    logic start_m, start_s; // Start strobe sync
    logic shut_m, shut_s; // Shutter sync
    logic sup_m, sup_s; // Supply good sync
    logic test_m, test_s; // Test pin sync, status only
    logic pend; // Clock edge waiting for room
    logic pend_start; // Start level with that edge
    seq_state_type st; // Sequence phase
    logic [IDX_W-1:0] cnt; // Clock number since start
    logic [IDX_W-1:0] grp; // Group now output
    cfg_type cfg; // Software setting
    cfg_type lcfg; // Setting for this line
    logic integ; // Integration running
    logic pd_n; // Power-down reset, low active
    logic line_done; // Last group pushed
    logic job_v; // Job waiting for combiner
    job_type job; // Job contents
    logic [31:0] prdata; // Read data
  } seq_type;

  seq_type q_r;
  seq_type q_nxt;
  logic edge_seen; // Sensor clock rising edge
  logic go; // Edge processed this cycle
  logic take_start; // Processed edge carries a start
  logic [IDX_W-1:0] last; // Index of the final group
  logic [IDX_W-1:0] c; // Clock number after this edge
  logic job_ready;
  logic [PIX_W-1:0] cmb_data;
  logic cmb_valid;
  logic fifo_ready;
  logic access;

  assign edge_seen = q_r.lclk_s & ~q_r.lclk_p;
  assign take_start = q_r.pend ? q_r.pend_start : q_r.start_s; // R2
  // Edges wait while a job is queued; this is the back-pressure path
  assign go = (edge_seen | q_r.pend) & ~q_r.job_v & q_r.pd_n;
  assign last = group_count(q_r.lcfg.variant, q_r.lcfg.res) - IDX_W'(1); // R9
  assign c = q_r.cnt + IDX_W'(1);
  assign access = psel & penable;

  // Status word assembly
  function automatic logic [31:0] stat_word(input seq_type s, input logic full);
    logic [31:0] w;
    w = '0;
    w[STAT_ST +: 3] = s.st;
    w[STAT_PD] = s.pd_n;
    w[STAT_INT] = s.integ;
    w[STAT_FULL] = full;
    w[STAT_TEST] = s.test_s;
    w[STAT_GRP +: IDX_W] = s.grp;
    return w;
  endfunction

  // Push a pixel group request for group g
  function automatic job_type pix_job(input cfg_type l, input logic [IDX_W-1:0] g);
    job_type j;
    j.dark = 1'b0;
    j.mode = l.mode; // R10
    j.res = l.res; // R8
    j.base = IDX_W'(g << l.res);
    return j;
  endfunction

  // Next state of the whole block
  always_comb begin
    q_nxt = q_r;
    q_nxt.line_done = 1'b0;
    // Pins pass two flops before anything reads them
    q_nxt.lclk_m = sensor_clk_in;
    q_nxt.lclk_s = q_r.lclk_m;
    q_nxt.lclk_p = q_r.lclk_s;
    q_nxt.start_m = start_in;
    q_nxt.start_s = q_r.start_m;
    q_nxt.shut_m = shutter_hold_in;
    q_nxt.shut_s = q_r.shut_m; // R11
    q_nxt.sup_m = supply_ok_in;
    q_nxt.sup_s = q_r.sup_m;
    q_nxt.test_m = test_mode_enable_in;
    q_nxt.test_s = q_r.test_m;
    q_nxt.pd_n = q_r.sup_s; // R13
    // Job leaves when the combiner takes it
    if (q_r.job_v && job_ready) begin
      q_nxt.job_v = 1'b0;
    end
    // An edge arriving while the pending one is consumed is kept
    if (edge_seen && (go ? q_r.pend : 1'b1)) begin
      q_nxt.pend = 1'b1;
      q_nxt.pend_start = q_r.start_s;
    end else if (go) begin
      q_nxt.pend = 1'b0;
    end
    if (go) begin
      if (take_start) begin
        // New line: sample, then reset capacitors
        q_nxt.st = ST_SAMPLE; // R1
        q_nxt.cnt = IDX_W'(1);
        q_nxt.grp = '0;
        q_nxt.lcfg = q_r.cfg;
        q_nxt.integ = 1'b0;
      end else begin
        unique case (q_r.st)
          ST_IDLE: begin
            // Clocks without a start do nothing
            q_nxt.st = ST_IDLE;
          end
          ST_SAMPLE: begin
            q_nxt.cnt = c;
            if (c > SAMPLE_END) begin
              q_nxt.st = ST_DISCH; // R3
            end
          end
          ST_DISCH: begin
            q_nxt.cnt = c;
            if (c > DISCH_END) begin
              // Capacitors released; first dark word
              q_nxt.st = ST_DARK; // R3
              q_nxt.integ = 1'b1;
              q_nxt.job_v = 1'b1;
              q_nxt.job = '{dark: 1'b1, mode: 1'b0, res: 2'b00, base: '0}; // R4
            end
          end
          ST_DARK: begin
            q_nxt.cnt = c;
            q_nxt.job_v = 1'b1;
            if (c > DARK_END) begin
              q_nxt.st = ST_READ; // R4
              q_nxt.job = pix_job(q_r.lcfg, '0);
            end else begin
              q_nxt.job = '{dark: 1'b1, mode: 1'b0, res: 2'b00, base: '0}; // R4
            end
          end
          ST_READ: begin
            q_nxt.job_v = 1'b1;
            if (q_r.grp == last) begin
              // Wrap to the first group, held values reread
              q_nxt.grp = '0; // R7
              q_nxt.job = pix_job(q_r.lcfg, '0);
            end else begin
              q_nxt.grp = q_r.grp + IDX_W'(1); // R5
              q_nxt.job = pix_job(q_r.lcfg, q_r.grp + IDX_W'(1));
              q_nxt.line_done = (q_r.grp + IDX_W'(1) == last); // R6
            end
          end
        endcase
      end
    end
    // Low supply forces idle with capacitors discharged
    if (!q_r.pd_n) begin
      q_nxt.st = ST_IDLE; // R15
      q_nxt.cnt = '0;
      q_nxt.grp = '0;
      q_nxt.integ = 1'b0;
      q_nxt.pend = 1'b0;
      q_nxt.job_v = 1'b0;
    end
    // Read data captured in the setup cycle
    if (psel && !penable) begin
      if (paddr == ADDR_CTRL) begin
        q_nxt.prdata = 32'(q_r.cfg);
      end else if (paddr == ADDR_STAT) begin
        q_nxt.prdata = stat_word(q_r, !fifo_ready);
      end else begin
        q_nxt.prdata = '0;
      end
    end
    // Control write at the completing edge
    if (pready && pwrite && paddr == ADDR_CTRL) begin
      q_nxt.cfg.res = pwdata[CTRL_RES +: 2]; // R8
      q_nxt.cfg.mode = pwdata[CTRL_MODE]; // R10
      q_nxt.cfg.variant = pwdata[CTRL_VAR +: 2];
    end
  end

  // State register; the enable freezes everything
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_r <= '0;
    end else if (clk_en) begin
      q_r <= q_nxt;
    end
  end

  // Zero-wait slave; a frozen block holds the bus off
  assign pready = access & clk_en;
  assign pslverr = pready & (paddr != ADDR_CTRL) & (paddr != ADDR_STAT);
  assign prdata = q_r.prdata;
  assign power_down_reset_n = q_r.pd_n; // R13
  assign hold_capture = (q_r.st == ST_SAMPLE); // R3
  assign cap_discharge = (q_r.st == ST_DISCH) | ~q_r.pd_n; // R15
  assign photodiode_connect = q_r.integ & ~q_r.shut_s; // R12
  assign line_done = q_r.line_done;

  pixel_combiner u_comb (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .job(q_r.job),
    .job_valid(q_r.job_v),
    .job_ready(job_ready),
    .hold_addr(hold_addr),
    .hold_level_in(hold_level_in),
    .out_data(cmb_data),
    .out_valid(cmb_valid),
    .out_ready(fifo_ready)
  );

  pixel_fifo #(.WIDTH(PIX_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .in_data(cmb_data),
    .in_valid(cmb_valid),
    .in_ready(fifo_ready),
    .out_data(analog_pixel_out),
    .out_valid(pixel_valid),
    .out_ready(pixel_ready)
  );

  // Checks on the sequence
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_r1;
    clk_en && go && take_start |=> q_r.st == ST_SAMPLE && q_r.cnt == IDX_W'(1) && !q_r.integ;
  endproperty
  a_r1: assert property (p_r1) else $error("start did not open sampling"); // R1

  property p_r2;
    clk_en && q_r.pd_n && edge_seen && q_r.start_s && !q_r.job_v && !q_r.pend
      |=> q_r.st == ST_SAMPLE;
  endproperty
  a_r2: assert property (p_r2) else $error("start edge not taken"); // R2

  property p_r3;
    q_r.st == ST_DISCH |-> q_r.cnt > SAMPLE_END && q_r.cnt <= DISCH_END && cap_discharge;
  endproperty
  a_r3: assert property (p_r3) else $error("discharge outside clocks four to nine"); // R3

  property p_r4;
    q_r.st == ST_DARK |-> q_r.cnt > DISCH_END && q_r.cnt <= DARK_END && q_r.job.dark;
  endproperty
  a_r4: assert property (p_r4) else $error("dark phase out of range"); // R4

  property p_r5;
    clk_en && go && !take_start && q_r.st == ST_READ && q_r.grp != last
      |=> q_r.grp == $past(q_r.grp) + IDX_W'(1) && q_r.job_v;
  endproperty
  a_r5: assert property (p_r5) else $error("pixel order broken"); // R5

  property p_r6;
    q_r.line_done |-> q_r.grp == last && q_r.st == ST_READ;
  endproperty
  a_r6: assert property (p_r6) else $error("line end flagged early"); // R6

  property p_r7;
    clk_en && go && !take_start && q_r.st == ST_READ && q_r.grp == last
      |=> q_r.grp == '0 && q_r.st == ST_READ;
  endproperty
  a_r7: assert property (p_r7) else $error("readout did not wrap"); // R7

  property p_r9;
    q_r.job_v && !q_r.job.dark |-> q_r.job.base == IDX_W'(q_r.grp << q_r.lcfg.res);
  endproperty
  a_r9: assert property (p_r9) else $error("group base wrong"); // R9

  property p_r10;
    q_r.job_v && !q_r.job.dark |-> q_r.job.mode == q_r.lcfg.mode;
  endproperty
  a_r10: assert property (p_r10) else $error("combine mode lost"); // R10

  property p_r12;
    q_r.shut_s |-> !photodiode_connect;
  endproperty
  a_r12: assert property (p_r12) else $error("photodiodes connected under shutter"); // R12

  property p_r13;
    clk_en && !q_r.sup_s |=> !power_down_reset_n;
  endproperty
  a_r13: assert property (p_r13) else $error("power-down reset not shown"); // R13

  property p_r15;
    clk_en && !q_r.pd_n |=> q_r.st == ST_IDLE && !q_r.job_v && !q_r.integ;
  endproperty
  a_r15: assert property (p_r15) else $error("sequencer ran in power-down"); // R15

  c_line: cover property (q_r.line_done);
  c_wrap: cover property (q_r.st == ST_READ && q_r.grp == last ##1 q_r.grp == '0);
  c_shut: cover property (q_r.integ && q_r.shut_s);
  c_stall: cover property (q_r.pend && q_r.job_v && !pixel_ready);
endmodule
`default_nettype wire

// ### verif/sensor_ctrl_model.sv
// Purpose: Controller model driving sensor clock, start strobe and shutter
// Assumes: Sensor clock far slower than pclk, all changes at pclk rise
// Notes: The sensor clock finishes its high half, then stands low while run is low
`timescale 1ns/1ps
`default_nettype none
module sensor_ctrl_model #(
  parameter int HALF = 6
) (
  input wire logic pclk,
  input wire logic run,
  input wire logic start_req,
  input wire logic shut_req,
  output logic sensor_clk_in,
  output logic start_in,
  output logic shutter_hold_in,
  output var int edges
);
  int cnt; // Cycles spent in the current half period
  initial begin
    sensor_clk_in = 1'b0;
    start_in = 1'b0;
    shutter_hold_in = 1'b0;
    edges = 0;
    cnt = 0;
  end
  // Start only moves while the clock is low, and never on the pclk edge that
  // raises the clock, so it is already settled at each rise
  always @(posedge pclk) begin
    shutter_hold_in <= shut_req;
    if (!sensor_clk_in && cnt != HALF - 1) start_in <= start_req;
    if (!run && !sensor_clk_in) begin
      cnt <= 0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      sensor_clk_in <= !sensor_clk_in;
      // Count rises since the last start, one per clock supplied
      if (!sensor_clk_in) edges <= start_in ? 1 : edges + 1;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule
`default_nettype wire

// ### verif/linear_sensor_readout_sequencer_bench.sv
// Purpose: Self-checking bench for the line sensor readout sequencer
// Assumes: One start per line, consumer ready at random
// Notes: Expected words come from a queue model of the held levels
`timescale 1ns/1ps
`default_nettype none
module linear_sensor_readout_sequencer_bench
  import sensor_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic sensor_clk_in, start_in, shutter_hold_in, supply_ok_in;
  logic power_down_reset_n, hold_capture, cap_discharge, photodiode_connect, line_done;
  logic run, start_req, shut_req, rdy_hold, chk_state; // Bench controls
  logic [IDX_W-1:0] hold_addr;
  logic [PIX_W-1:0] hold_level_in, analog_pixel_out;
  logic pixel_valid, pixel_ready;
  logic [PIX_W-1:0] hold_mem [1024]; // Held level of every pixel
  logic [PIX_W-1:0] exp_q [$]; // Words still owed by the sequencer
  int edges, dones, end_edge, miscompares, check_count;
  int ntab [4] = '{1024, 960, 640, 320};
  // Variant, mode, resolution per line; every code and mode appears
  logic [4:0] cfg_tab [9] = '{5'h18, 5'h15, 5'h0a, 5'h07, 5'h00, 5'h19, 5'h16, 5'h0b, 5'h10};

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = !pclk;
  end

  assign hold_level_in = hold_mem[hold_addr[9:0]]; // Same-cycle answer

  sensor_sequencer sensor_sequencer_i (
    .pclk(pclk), .presetn(presetn), .clk_en(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sensor_clk_in(sensor_clk_in), .start_in(start_in),
    .shutter_hold_in(shutter_hold_in), .supply_ok_in(supply_ok_in),
    .test_mode_enable_in(1'b0),
    .power_down_reset_n(power_down_reset_n), .hold_capture(hold_capture),
    .cap_discharge(cap_discharge), .photodiode_connect(photodiode_connect),
    .line_done(line_done), .hold_addr(hold_addr), .hold_level_in(hold_level_in),
    .analog_pixel_out(analog_pixel_out), .pixel_valid(pixel_valid),
    .pixel_ready(pixel_ready)
  );

  sensor_ctrl_model #(.HALF(6)) sensor_ctrl_model_i (
    .pclk(pclk), .run(run), .start_req(start_req), .shut_req(shut_req),
    .sensor_clk_in(sensor_clk_in), .start_in(start_in),
    .shutter_hold_in(shutter_hold_in), .edges(edges)
  );

  task automatic close_out;
    if (miscompares == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] want, input string m);
    check_count++;
    if (got !== want) begin
      miscompares++;
      $display("MISMATCH %0t %s got %h want %h", $time, m, got, want);
    end
  endtask

  task automatic timeout;
    cmp(32'h0, 32'h1, "timeout");
    close_out;
  endtask

  // One APB transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int t;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) timeout();
  endtask

  // Wait for clock count k, optionally until the clock is low again
  task automatic wait_edges(input int k, input bit lo);
    int t;
    for (t = 0; t < 20000 && (edges != k || (lo && sensor_clk_in)); t++) @(posedge pclk);
    if (edges != k) timeout();
  endtask

  // One line: set config, queue the expected words, clock it out and drain
  task automatic do_line(input logic [4:0] c);
    int g, nc, s, t;
    logic [31:0] r;
    logic e;
    g = ntab[c[4:3]] >> c[1:0];
    nc = 16 + g + 3; // Three clocks past the line end wrap around
    apb(1'b1, ADDR_CTRL, {27'h0, c}, r, e);
    cmp(e, 1'b0, "mapped write error");
    apb(1'b0, ADDR_CTRL, 32'h0, r, e);
    cmp(r, {27'h0, c}, "ctrl readback");
    repeat (7) exp_q.push_back(DARK_LEVEL);
    for (int k = 17; k <= nc; k++) begin
      s = 0;
      for (int j = 0; j < (1 << c[1:0]); j++) s += hold_mem[(((k - 17) % g) << c[1:0]) + j];
      exp_q.push_back(PIX_W'(c[2] ? (s > 4095 ? 4095 : s) : s >> c[1:0]));
    end
    dones = 0;
    chk_state <= 1'b1;
    rdy_hold <= (c == 5'h18);
    start_req <= 1'b1;
    run <= 1'b1;
    wait_edges(1, 1'b0);
    start_req <= 1'b0;
    wait_edges(12, 1'b1);
    shut_req <= c[0];
    // First line: stall the consumer until the buffer refuses, then release
    if (c == 5'h18) begin
      wait_edges(14, 1'b1);
      run <= 1'b0;
      apb(1'b0, ADDR_STAT, 32'h0, r, e);
      cmp(r[STAT_FULL], 1'b1, "buffer full");
      cmp(pixel_valid, 1'b1, "valid while full");
      rdy_hold <= 1'b0;
      run <= 1'b1;
    end
    wait_edges(20, 1'b1);
    shut_req <= 1'b0;
    wait_edges(nc, 1'b1);
    run <= 1'b0;
    for (t = 0; t < 2000 && (exp_q.size() > 0 || pixel_valid !== 1'b0); t++) @(posedge pclk);
    cmp(exp_q.size(), 0, "words left");
    cmp(dones, 1, "line end pulses");
    cmp(end_edge, 16 + g, "line end clock");
    cmp(pixel_valid, 1'b0, "stream drained");
    chk_state <= 1'b0;
  endtask

  // Consumer ready at random, held low during the buffer-fill scenario
  always @(posedge pclk) pixel_ready <= rdy_hold ? 1'b0 : ($urandom % 4 != 0);

  // Every word taken from the stream must be the next one owed
  always @(posedge pclk) begin
    if (presetn === 1'b1 && pixel_valid === 1'b1 && pixel_ready === 1'b1) begin
      if (exp_q.size() == 0) cmp(32'h1, 32'h0, "unexpected word");
      else cmp(analog_pixel_out, exp_q.pop_front(), "word");
    end
    // Remember which sensor clock closed the line
    if (line_done === 1'b1) begin
      dones <= dones + 1;
      end_edge <= edges;
    end
  end

  // Phase outputs checked mid-clock, long after each rise has settled
  always @(negedge sensor_clk_in) begin
    if (chk_state) begin
      cmp(hold_capture, edges >= 1 && edges <= 3, "sampling");
      cmp(cap_discharge, edges >= 4 && edges <= 9, "discharge");
      cmp(photodiode_connect, edges >= 10 && !shutter_hold_in, "integrate");
    end
  end

  initial begin
    logic [31:0] r;
    logic e;
    void'($urandom(52597));
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {presetn, supply_ok_in, run, start_req, shut_req, rdy_hold, chk_state} = '0;
    pixel_ready = 1'b0;
    miscompares = 0;
    check_count = 0;
    dones = 0;
    foreach (hold_mem[i]) hold_mem[i] = PIX_W'($urandom);
    repeat (4) @(posedge pclk);
    cmp(power_down_reset_n, 1'b0, "reset out in reset");
    cmp(cap_discharge, 1'b1, "discharged in reset");
    cmp(pixel_valid, 1'b0, "no word in reset");
    presetn <= 1'b1;
    supply_ok_in <= 1'b1;
    repeat (6) @(posedge pclk);
    cmp(power_down_reset_n, 1'b1, "reset out released");
    apb(1'b0, ADDR_STAT, 32'h0, r, e);
    cmp(r[STAT_TEST], 1'b0, "test pin low");
    cmp(r[STAT_PD], 1'b1, "status reset out");
    apb(1'b1, 12'h008, 32'hffff_ffff, r, e);
    cmp(e, 1'b1, "unmapped write error");
    apb(1'b0, 12'h008, 32'h0, r, e);
    cmp(r, 32'h0, "unmapped read data");
    foreach (cfg_tab[i]) do_line(cfg_tab[i]);
    // Supply loss: sensor clocks and starts must be ignored
    supply_ok_in <= 1'b0;
    repeat (6) @(posedge pclk);
    cmp(power_down_reset_n, 1'b0, "reset out on supply loss");
    cmp(cap_discharge, 1'b1, "discharged on supply loss");
    start_req <= 1'b1;
    run <= 1'b1;
    wait_edges(1, 1'b0);
    start_req <= 1'b0;
    wait_edges(20, 1'b1);
    run <= 1'b0;
    apb(1'b0, ADDR_STAT, 32'h0, r, e);
    cmp(r[2:0], 3'h0, "idle in power-down");
    cmp(pixel_valid, 1'b0, "no word in power-down");
    close_out;
  end
endmodule
`default_nettype wire
